// *** rtl/serial_control_pkg.sv ***
package serial_control_pkg;

  // Control word layout, address bits first on the wire
  localparam int CTRL_WIDTH = 5;
  localparam int CHAN_WIDTH = 3;
  localparam int CHAN_COUNT = 8;
  localparam int RESULT_WIDTH = 12;

  // Bit positions inside the shifted word
  localparam int POS_CHAN_SEL_BIT2 = 4;
  localparam int POS_CHAN_SEL_BIT1 = 3;
  localparam int POS_CHAN_SEL_BIT0 = 2;
  localparam int POS_CONVERT_ON_WRITE = 1;
  localparam int POS_POWER_DOWN = 0;

  localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 5'h00;

  // Serial clock counts for a write and for a standby write
  localparam int COUNT_WIDTH = 3;
  localparam logic [COUNT_WIDTH-1:0] WRITE_CLOCKS = 3'h6;
  localparam logic [COUNT_WIDTH-1:0] STANDBY_CLOCKS = 3'h7;

  // Settling pulse stands in for the external timing capacitor
  localparam int SETTLE_TIME_NS = 2000;
  localparam int CLOCK_PERIOD_NS = 10;
  localparam int SETTLE_CYCLES = (SETTLE_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

  typedef struct packed {
    logic [CHAN_WIDTH-1:0] chan_sel;
    logic convert_on_write_bit;
    logic power_down_bit;
  } ctrl_word_t;

endpackage

// *** rtl/level_sync.sv ***
`timescale 1ns/10ps
`default_nettype none

module level_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  // Destination clock and reset
  input wire logic clock,
  input wire logic reset,
  // Level from another domain
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  // First stage feeds only the second stage
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      stage1 <= RESET_VALUE;
      sync_out <= RESET_VALUE;
    end
    else
    begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule // level_sync

`default_nettype wire

// *** rtl/settle_timer.sv ***
`timescale 1ns/10ps
`default_nettype none

module settle_timer #(
  parameter int CYCLES = serial_control_pkg::SETTLE_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Restart and state
  input wire logic start,
  output logic active,
  output logic expired
);

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LOAD = CW'(CYCLES);

  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic next_active;
  logic next_expired;

  always_comb
  begin
    next_count = count;
    next_active = active;
    next_expired = 1'b0;
    // A new request restarts the full width
    if (start)
    begin
      next_count = LOAD;
      next_active = 1'b1;
    end
    else if (active)
    begin
      if (count == CW'(1))
      begin
        next_active = 1'b0;
        next_expired = 1'b1;
      end
      next_count = count - CW'(1);
    end
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      count <= '0;
      active <= 1'b0;
      expired <= 1'b0;
    end
    else
    begin
      count <= next_count;
      active <= next_active;
      expired <= next_expired;
    end
  end

endmodule // settle_timer

`default_nettype wire

// *** rtl/serial_control_write.sv ***
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - Holds a five-bit control word loaded from the serial port.
// - A write loads only after six serial clocks with frame sync low.
// - Standby writes need seven serial clocks inside the frame.
// - Frame ending before six clocks leaves the register unchanged.
// - Convert-on-write set starts a conversion on every write frame outside a conversion or standby.
// - Power-on clears every control bit.
// - Bipolar range gives 12-bit two's complement results.
// - Unipolar ranges give straight binary results.
// - Three select bits, MSB first, then convert, then power-down.
// - Address write outside a conversion starts settling pulse; conversion held off until it expires.
// - Convert-on-write starts after sixth clock and disables the start pin.
// - Power-down enters standby on seventh falling edge; zero restores normal.
module serial_control_write #(
  parameter int SETTLE_CYCLES = serial_control_pkg::SETTLE_CYCLES
) (
  // System clock and reset
  input wire logic CLOCK,
  input wire logic RESET,
  // Serial write port from the host
  input wire logic SCLK,
  input wire logic WRITE_FRAME_SYNC_N,
  input wire logic SERIAL_DATA_IN,
  // Hardware conversion start pin
  input wire logic HW_CONVERT_START_N,
  // Converter core result
  input wire logic BIPOLAR_RANGE,
  input wire logic [serial_control_pkg::RESULT_WIDTH-1:0] RAW_RESULT,
  input wire logic RAW_RESULT_VALID,
  // Control outputs
  output logic [serial_control_pkg::CHAN_WIDTH-1:0] CHAN_SEL,
  output logic CONVERT_ON_WRITE,
  output logic STANDBY,
  output logic SETTLE_ACTIVE,
  output logic HOLD_CONVERT,
  output logic CONVERTING,
  // Formatted result
  output logic [serial_control_pkg::RESULT_WIDTH-1:0] RESULT_CODE,
  output logic RESULT_VALID
);

  typedef enum logic [1:0] {IDLE, SETTLE, CONVERT} convert_on_write_bit_state_t;

  // Raw result is offset binary; bipolar flips the MSB
  function automatic logic [serial_control_pkg::RESULT_WIDTH-1:0] format_code(
    input logic bipolar,
    input logic [serial_control_pkg::RESULT_WIDTH-1:0] raw
  );
    logic [serial_control_pkg::RESULT_WIDTH-1:0] code;
    code = raw;
    if (bipolar)
    begin
      code[serial_control_pkg::RESULT_WIDTH-1] = ~raw[serial_control_pkg::RESULT_WIDTH-1];
    end
    return code;
  endfunction

  // Link domain, falling SCLK edges
  logic [serial_control_pkg::CTRL_WIDTH-1:0] shifter;
  logic [serial_control_pkg::CTRL_WIDTH-1:0] next_shifter;
  logic [serial_control_pkg::COUNT_WIDTH-1:0] bit_count;
  logic [serial_control_pkg::COUNT_WIDTH-1:0] next_bit_count;
  logic [serial_control_pkg::CTRL_WIDTH-1:0] link_word;
  logic [serial_control_pkg::CTRL_WIDTH-1:0] next_link_word;
  logic commit_toggle;
  logic next_commit_toggle;
  logic standby_toggle;
  logic next_standby_toggle;
  logic link_clear;

  always_comb
  begin
    next_shifter = shifter;
    next_bit_count = bit_count;
    next_link_word = link_word;
    next_commit_toggle = commit_toggle;
    next_standby_toggle = standby_toggle;
    if (bit_count != serial_control_pkg::STANDBY_CLOCKS)
    begin
      next_bit_count = bit_count + serial_control_pkg::COUNT_WIDTH'(1);
    end
    if (bit_count < serial_control_pkg::COUNT_WIDTH'(serial_control_pkg::CTRL_WIDTH))
    begin
      next_shifter = {shifter[serial_control_pkg::CTRL_WIDTH-2:0], SERIAL_DATA_IN};
    end
    if (bit_count == serial_control_pkg::WRITE_CLOCKS - serial_control_pkg::COUNT_WIDTH'(1))
    begin
      next_link_word = shifter;
      next_commit_toggle = ~commit_toggle;
    end
    if (bit_count == serial_control_pkg::STANDBY_CLOCKS - serial_control_pkg::COUNT_WIDTH'(1))
    begin
      next_standby_toggle = ~standby_toggle;
    end
  end

  // frame sync high clears the count, so a short frame commits nothing
  assign link_clear = RESET | WRITE_FRAME_SYNC_N;
  always_ff @(negedge SCLK or posedge link_clear)
  begin
    if (link_clear)
    begin
      bit_count <= '0;
      shifter <= serial_control_pkg::CTRL_RESET;
    end
    else
    begin
      bit_count <= next_bit_count;
      shifter <= next_shifter;
    end
  end

  // Held across frames so the core can read it after the toggle
  always_ff @(negedge SCLK or posedge RESET)
  begin
    if (RESET)
    begin
      link_word <= serial_control_pkg::CTRL_RESET;
      commit_toggle <= 1'b0;
      standby_toggle <= 1'b0;
    end
    else if (!WRITE_FRAME_SYNC_N)
    begin
      link_word <= next_link_word;
      commit_toggle <= next_commit_toggle;
      standby_toggle <= next_standby_toggle;
    end
  end

  // Crossing into the system domain
  logic [3:0] sync_in;
  logic [3:0] sync_out;
  logic commit_seen;
  logic standby_seen;
  logic frame_sync_seen;
  logic start_pin_seen;

  assign sync_in = {commit_toggle, standby_toggle, WRITE_FRAME_SYNC_N, HW_CONVERT_START_N};

  level_sync #(
    .WIDTH(4),
    .RESET_VALUE(4'h3)
  ) u_sync (
    .clock(CLOCK),
    .reset(RESET),
    .async_in(sync_in),
    .sync_out(sync_out)
  );

  serial_control_pkg::ctrl_word_t conversion_control;
  serial_control_pkg::ctrl_word_t next_conversion_control;
  convert_on_write_bit_state_t state;
  convert_on_write_bit_state_t next_state;
  logic next_standby;
  logic frame_committed;
  logic next_frame_committed;
  logic next_hold_convert;
  logic next_converting;
  logic [serial_control_pkg::RESULT_WIDTH-1:0] next_result_code;
  logic next_result_valid;
  logic settle_start;
  logic settle_active;
  logic settle_expired;
  logic commit_pulse;
  logic standby_pulse;
  logic frame_open;
  logic frame_close;
  logic pin_start;
  logic start_request;

  assign commit_pulse = sync_out[3] ^ commit_seen;
  assign standby_pulse = sync_out[2] ^ standby_seen;
  assign frame_open = frame_sync_seen & ~sync_out[1];
  assign frame_close = ~frame_sync_seen & sync_out[1];
  assign pin_start = start_pin_seen & ~sync_out[0];

  always_comb
  begin
    next_conversion_control = conversion_control;
    next_standby = STANDBY;
    next_frame_committed = frame_committed;
    start_request = 1'b0;
    settle_start = 1'b0;
    if (frame_open)
    begin
      next_frame_committed = 1'b0;
    end
    // load the word only on a counted commit
    if (commit_pulse)
    begin
      next_conversion_control = serial_control_pkg::ctrl_word_t'(link_word);
      next_frame_committed = 1'b1;
      settle_start = 1'b1;
      start_request = link_word[serial_control_pkg::POS_CONVERT_ON_WRITE];
      if (!link_word[serial_control_pkg::POS_POWER_DOWN])
      begin
        next_standby = 1'b0;
      end
    end
    else if (frame_close && !frame_committed && conversion_control.convert_on_write_bit)
    begin
      start_request = 1'b1;
      settle_start = 1'b1;
    end
    // start pin ignored while convert-on-write is set
    if (pin_start && !conversion_control.convert_on_write_bit && !commit_pulse)
    begin
      start_request = 1'b1;
      settle_start = 1'b1;
    end
    // standby only after the seventh edge
    if (standby_pulse && link_word[serial_control_pkg::POS_POWER_DOWN])
    begin
      next_standby = 1'b1;
    end
    // Requests during a conversion are dropped
    if (state == CONVERT)
    begin
      start_request = 1'b0;
      settle_start = 1'b0;
    end
  end

  settle_timer #(
    .CYCLES(SETTLE_CYCLES)
  ) u_settle (
    .clock(CLOCK),
    .reset(RESET),
    .start(settle_start),
    .active(settle_active),
    .expired(settle_expired)
  );

  always_comb
  begin
    next_state = state;
    next_hold_convert = 1'b0;
    next_converting = CONVERTING;
    next_result_code = RESULT_CODE;
    next_result_valid = 1'b0;
    case (state)
      IDLE:
      begin
        if (start_request)
        begin
          next_state = SETTLE;
        end
      end
      SETTLE:
      begin
        // hold and convert once settling ends
        if (settle_expired && !settle_start)
        begin
          next_state = CONVERT;
          next_hold_convert = 1'b1;
          next_converting = 1'b1;
        end
      end
      CONVERT:
      begin
        if (RAW_RESULT_VALID)
        begin
          next_state = IDLE;
          next_converting = 1'b0;
          next_result_code = format_code(BIPOLAR_RANGE, RAW_RESULT);
          next_result_valid = 1'b1;
        end
      end
      default:
      begin
        next_state = IDLE;
      end
    endcase
    // Standby aborts conversion activity
    if (STANDBY)
    begin
      next_state = IDLE;
      next_converting = 1'b0;
    end
  end

  always_ff @(posedge CLOCK or posedge RESET)
  begin
    if (RESET)
    begin
      conversion_control <= serial_control_pkg::ctrl_word_t'(serial_control_pkg::CTRL_RESET);
      commit_seen <= 1'b0;
      standby_seen <= 1'b0;
      frame_sync_seen <= 1'b1;
      start_pin_seen <= 1'b1;
      frame_committed <= 1'b0;
      state <= IDLE;
      STANDBY <= 1'b0;
      HOLD_CONVERT <= 1'b0;
      CONVERTING <= 1'b0;
      RESULT_CODE <= '0;
      RESULT_VALID <= 1'b0;
      CHAN_SEL <= '0;
      CONVERT_ON_WRITE <= 1'b0;
      SETTLE_ACTIVE <= 1'b0;
    end
    else
    begin
      conversion_control <= next_conversion_control;
      commit_seen <= sync_out[3];
      standby_seen <= sync_out[2];
      frame_sync_seen <= sync_out[1];
      start_pin_seen <= sync_out[0];
      frame_committed <= next_frame_committed;
      state <= next_state;
      STANDBY <= next_standby;
      HOLD_CONVERT <= next_hold_convert;
      CONVERTING <= next_converting;
      RESULT_CODE <= next_result_code;
      RESULT_VALID <= next_result_valid;
      CHAN_SEL <= next_conversion_control.chan_sel;
      CONVERT_ON_WRITE <= next_conversion_control.convert_on_write_bit;
      SETTLE_ACTIVE <= settle_active;
    end
  end

endmodule // serial_control_write

`default_nettype wire

// *** dv/serial_host_model.sv ***
`timescale 1ns/10ps
`default_nettype none

module serial_host_model (
  // Serial write port towards the block
  output logic sclk,
  output logic frame_sync_n,
  output logic data
);
  initial
  begin
    sclk = 1'b1;
    frame_sync_n = 1'b1;
    data = 1'b0;
  end

  // Clock stands still high outside frames
  task automatic send(input logic [4:0] word, input int n);
    frame_sync_n = 1'b0;
    #15;
    for (int i = 0; i < n; i++)
    begin
      sclk = 1'b1;
      data = (i < 5) ? word[4 - i] : ~data;
      #15;
      sclk = 1'b0;
      #15;
    end
    sclk = 1'b1;
    #15;
    frame_sync_n = 1'b1;
    // Released line must not look like held data
    data = ~data;
    #60;
  endtask
endmodule // serial_host_model

`default_nettype wire

// *** dv/serial_control_write_assertions.sv ***
`timescale 1ns/10ps
`default_nettype none

module serial_control_write_assertions #(
  parameter int SETTLE_CYCLES = serial_control_pkg::SETTLE_CYCLES
) (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RESET,
  // Watched inputs
  input wire logic WRITE_FRAME_SYNC_N,
  input wire logic BIPOLAR_RANGE,
  input wire logic [11:0] RAW_RESULT,
  input wire logic RAW_RESULT_VALID,
  // Watched outputs
  input wire logic [2:0] CHAN_SEL,
  input wire logic CONVERT_ON_WRITE,
  input wire logic STANDBY,
  input wire logic SETTLE_ACTIVE,
  input wire logic HOLD_CONVERT,
  input wire logic CONVERTING,
  input wire logic [11:0] RESULT_CODE,
  input wire logic RESULT_VALID
);
  logic [3:0] idle_cnt, next_idle_cnt;
  logic [15:0] settle_cnt, next_settle_cnt;

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (RESET);

  always_comb
  begin
    next_idle_cnt = 4'h0;
    if (WRITE_FRAME_SYNC_N)
      next_idle_cnt = (idle_cnt == 4'hf) ? idle_cnt : idle_cnt + 4'h1;
    next_settle_cnt = SETTLE_ACTIVE ? settle_cnt + 16'h1 : 16'h0;
  end

  always_ff @(posedge CLOCK or posedge RESET)
  begin
    if (RESET)
    begin
      idle_cnt <= 4'h0;
      settle_cnt <= 16'h0;
    end
    else
    begin
      idle_cnt <= next_idle_cnt;
      settle_cnt <= next_settle_cnt;
    end
  end

  property p_reset_clear;
    $fell(RESET) |-> CHAN_SEL == 3'h0 && !CONVERT_ON_WRITE && !STANDBY;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("control word not clear after reset");

  // Long idle frame means nothing may commit
  property p_idle_stable;
    idle_cnt == 4'hf |-> $stable({CHAN_SEL, CONVERT_ON_WRITE, STANDBY});
  endproperty
  a_idle_stable: assert property (p_idle_stable)
    else $error("control word changed outside a frame");

  property p_settle_len;
    $fell(SETTLE_ACTIVE) && !STANDBY |-> int'(settle_cnt) >= SETTLE_CYCLES;
  endproperty
  a_settle_len: assert property (p_settle_len)
    else $error("settling pulse too short");

  property p_no_hold_in_settle;
    HOLD_CONVERT |-> !SETTLE_ACTIVE;
  endproperty
  a_no_hold_in_settle: assert property (p_no_hold_in_settle)
    else $error("hold during settling pulse");

  property p_settle_to_hold;
    $fell(SETTLE_ACTIVE) && CONVERT_ON_WRITE && !STANDBY && !CONVERTING |-> ##[0:3] HOLD_CONVERT;
  endproperty
  a_settle_to_hold: assert property (p_settle_to_hold)
    else $error("no hold after settling");

  property p_hold_starts;
    HOLD_CONVERT |=> CONVERTING && !HOLD_CONVERT;
  endproperty
  a_hold_starts: assert property (p_hold_starts)
    else $error("hold did not start conversion");

  property p_result_fmt;
    CONVERTING && RAW_RESULT_VALID |=> RESULT_VALID
      && RESULT_CODE == ($past(RAW_RESULT) ^ {$past(BIPOLAR_RANGE), 11'h000});
  endproperty
  a_result_fmt: assert property (p_result_fmt)
    else $error("result code format wrong");

  property p_result_pulse;
    RESULT_VALID |=> !RESULT_VALID && !CONVERTING;
  endproperty
  a_result_pulse: assert property (p_result_pulse)
    else $error("result valid not a single pulse");

  c_standby: cover property ($rose(STANDBY));
  c_hold: cover property (HOLD_CONVERT);
  c_bipolar: cover property (RESULT_VALID && BIPOLAR_RANGE);
endmodule // serial_control_write_assertions

bind serial_control_write serial_control_write_assertions #(
  .SETTLE_CYCLES(SETTLE_CYCLES)
) u_serial_control_write_assertions (
  .CLOCK(CLOCK), .RESET(RESET), .WRITE_FRAME_SYNC_N(WRITE_FRAME_SYNC_N),
  .BIPOLAR_RANGE(BIPOLAR_RANGE), .RAW_RESULT(RAW_RESULT), .RAW_RESULT_VALID(RAW_RESULT_VALID),
  .CHAN_SEL(CHAN_SEL), .CONVERT_ON_WRITE(CONVERT_ON_WRITE), .STANDBY(STANDBY),
  .SETTLE_ACTIVE(SETTLE_ACTIVE), .HOLD_CONVERT(HOLD_CONVERT), .CONVERTING(CONVERTING),
  .RESULT_CODE(RESULT_CODE), .RESULT_VALID(RESULT_VALID)
);

`default_nettype wire

// *** dv/serial_control_write_tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none

`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin fail_count++; $display("ERROR %s expected %0h seen %0h", n, e, g); end end

module serial_control_write_tb_top;
  logic CLOCK, RESET, HW_CONVERT_START_N, BIPOLAR_RANGE, RAW_RESULT_VALID;
  logic SCLK, WRITE_FRAME_SYNC_N, SERIAL_DATA_IN;
  logic [11:0] RAW_RESULT, RESULT_CODE;
  logic [2:0] CHAN_SEL;
  logic CONVERT_ON_WRITE, STANDBY, SETTLE_ACTIVE, HOLD_CONVERT, CONVERTING, RESULT_VALID;
  int fail_count = 0;
  int n_compared = 0;
  int cycles = 0;
  int n_hold = 0;
  int n_convert_on_write_bit = 0;

  serial_host_model u_serial_host_model (
    .sclk(SCLK), .frame_sync_n(WRITE_FRAME_SYNC_N), .data(SERIAL_DATA_IN)
  );

  // Short settle keeps the run brief
  serial_control_write #(
    .SETTLE_CYCLES(5)
  ) u_serial_control_write (
    .CLOCK(CLOCK), .RESET(RESET), .SCLK(SCLK), .WRITE_FRAME_SYNC_N(WRITE_FRAME_SYNC_N),
    .SERIAL_DATA_IN(SERIAL_DATA_IN), .HW_CONVERT_START_N(HW_CONVERT_START_N),
    .BIPOLAR_RANGE(BIPOLAR_RANGE), .RAW_RESULT(RAW_RESULT), .RAW_RESULT_VALID(RAW_RESULT_VALID),
    .CHAN_SEL(CHAN_SEL), .CONVERT_ON_WRITE(CONVERT_ON_WRITE), .STANDBY(STANDBY),
    .SETTLE_ACTIVE(SETTLE_ACTIVE), .HOLD_CONVERT(HOLD_CONVERT), .CONVERTING(CONVERTING),
    .RESULT_CODE(RESULT_CODE), .RESULT_VALID(RESULT_VALID)
  );

  initial
  begin
    CLOCK = 1'b0;
    forever #5 CLOCK = ~CLOCK;
  end

  task automatic end_of_test();
    if (fail_count == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge CLOCK)
  begin
    cycles <= cycles + 1;
    if (HOLD_CONVERT === 1'b1)
      n_hold <= n_hold + 1;
    if (cycles == 20000)
    begin
      fail_count++;
      end_of_test();
    end
  end

  // Core answers once a conversion is running
  task automatic result(input logic [11:0] raw, input logic bip);
    for (int i = 0; i < 40 && CONVERTING !== 1'b1; i++)
      @(posedge CLOCK);
    @(posedge CLOCK);
    BIPOLAR_RANGE <= bip;
    RAW_RESULT <= raw;
    RAW_RESULT_VALID <= 1'b1;
    @(posedge CLOCK);
    RAW_RESULT_VALID <= 1'b0;
    n_convert_on_write_bit++;
    #1;
    `CHK("result_valid", 1'b1, RESULT_VALID)
    `CHK("result_code", (raw ^ {bip, 11'h000}), RESULT_CODE)
    `CHK("converting", 1'b0, CONVERTING)
    `CHK("hold_count", n_convert_on_write_bit, n_hold)
  endtask

  // Address writes may launch a conversion; finish it
  task automatic wr(input logic [4:0] w, input int n);
    u_serial_host_model.send(w, n);
    repeat (16) @(posedge CLOCK);
    if (CONVERTING === 1'b1)
      result(12'h5a3, 1'b0);
  endtask

  task automatic pin_pulse();
    @(posedge CLOCK);
    HW_CONVERT_START_N <= 1'b0;
    repeat (4) @(posedge CLOCK);
    HW_CONVERT_START_N <= 1'b1;
  endtask

  task automatic t_reset();
    `CHK("chan_sel", 3'h0, CHAN_SEL)
    `CHK("convert_on_write", 1'b0, CONVERT_ON_WRITE)
    `CHK("standby", 1'b0, STANDBY)
    `CHK("settle_active", 1'b0, SETTLE_ACTIVE)
    `CHK("converting", 1'b0, CONVERTING)
  endtask

  task automatic t_channels();
    for (int c = 0; c < 8; c++)
    begin
      wr({c[2:0], 2'b00}, 6);
      `CHK("chan_sel", c[2:0], CHAN_SEL)
    end
    wr(5'h08, 5);
    `CHK("chan_sel", 3'h7, CHAN_SEL)
  endtask

  task automatic t_convert();
    u_serial_host_model.send(5'h0e, 6);
    result(12'h8a5, 1'b0);
    `CHK("convert_on_write", 1'b1, CONVERT_ON_WRITE)
    repeat (20) @(posedge CLOCK);
    u_serial_host_model.send(5'h00, 2);
    result(12'h3c6, 1'b1);
    `CHK("chan_sel", 3'h3, CHAN_SEL)
    pin_pulse();
    repeat (20) @(posedge CLOCK);
    `CHK("settle_active", 1'b0, SETTLE_ACTIVE)
    `CHK("converting", 1'b0, CONVERTING)
    wr(5'h08, 6);
    pin_pulse();
    result(12'h7ff, 1'b1);
  endtask

  task automatic t_standby();
    wr(5'h05, 6);
    `CHK("standby", 1'b0, STANDBY)
    wr(5'h05, 7);
    `CHK("standby", 1'b1, STANDBY)
    wr(5'h04, 6);
    `CHK("standby", 1'b0, STANDBY)
  endtask

  initial
  begin
    RESET = 1'b1;
    HW_CONVERT_START_N = 1'b1;
    BIPOLAR_RANGE = 1'b0;
    RAW_RESULT = 12'h000;
    RAW_RESULT_VALID = 1'b0;
    repeat (16) @(posedge CLOCK);
    RESET <= 1'b0;
    repeat (3) @(posedge CLOCK);
    #1;
    t_reset();
    t_channels();
    t_convert();
    t_standby();
    end_of_test();
  end
endmodule // serial_control_write_tb_top

`default_nettype wire
